// ---- hw/tmso_defs.vh ----
// register offsets, field positions and reset values of the timer match status block
`ifndef TMSO_DEFS_VH
`define TMSO_DEFS_VH

`define TMSO_ADDR_W 2
`define TMSO_OFS_STATUS 2'h0
`define TMSO_OFS_IRQ_EN 2'h1

`define TMSO_BIT_MATCH_B 7
`define TMSO_BIT_MATCH_A 6
`define TMSO_BIT_OVERFLOW 5
`define TMSO_BIT_RESERVED 4
`define TMSO_BIT_OS_B_HI 3
`define TMSO_BIT_OS_B_LO 2
`define TMSO_BIT_OS_A_HI 1
`define TMSO_BIT_OS_A_LO 0

`define TMSO_STATUS_RESET 8'h10
`define TMSO_IRQ_EN_RESET 3'h0
`define TMSO_OS_RESET 2'h0
`define TMSO_RESERVED_VAL 1'b1

`define TMSO_OS_KEEP 2'h0
`define TMSO_OS_LOW 2'h1
`define TMSO_OS_HIGH 2'h2
`define TMSO_OS_TOGGLE 2'h3

`endif

// ---- hw/tmso_flag_cell.v ----
// one event flag: hardware set, cleared by software writing 0 after reading 1
`timescale 1ns/10ps
module tmso_flag_cell (
    input wire clk,          // timer clock
    input wire reset_n,      // async reset, active low
    input wire set_pulse,    // hardware event, one cycle
    input wire rd_reg,       // read strobe to the status register
    input wire wr_reg,       // write strobe to the status register
    input wire wr_bit,       // written value of this flag bit
    output reg flag_reg      // current flag value
);
    reg armed_reg;
    wire clear_ok;

    // armed only by a read that saw the flag at one
    assign clear_ok = wr_reg & ~wr_bit & armed_reg;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_reg <= 1'b0;
        end else if (wr_reg) begin
            armed_reg <= 1'b0;
        end else if (rd_reg && flag_reg) begin
            armed_reg <= 1'b1;
        end
    end

    // set wins over a coinciding clear; writing one keeps the flag
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= set_pulse | (flag_reg & ~clear_ok);
        end
    end
endmodule

// ---- hw/tmso_wave_out.v ----
// waveform output pin driven by compare matches A and B
`timescale 1ns/10ps
`include "tmso_defs.vh"
module tmso_wave_out (
    input wire clk,              // timer clock
    input wire reset_n,          // async reset, active low
    input wire match_a,          // compare match A strobe
    input wire match_b,          // compare match B strobe
    input wire [1:0] sel_a,      // output_select_a field
    input wire [1:0] sel_b,      // output_select_b field
    output reg pin_reg           // waveform_output_pin level
);
    reg after_a;
    reg pin_next;

    function apply_sel;
        input [1:0] sel;
        input cur;
        begin
            case (sel)
                `TMSO_OS_LOW: apply_sel = 1'b0;
                `TMSO_OS_HIGH: apply_sel = 1'b1;
                `TMSO_OS_TOGGLE: apply_sel = ~cur;
                default: apply_sel = cur;
            endcase
        end
    endfunction

    // matches in the same cycle: A is applied first, B last on its result, so B decides when sel_b is TMSO_OS_LOW or TMSO_OS_HIGH
    always @* begin
        after_a = pin_reg;
        pin_next = pin_reg;
        if (match_a) begin
            after_a = apply_sel(sel_a, pin_reg);
        end
        pin_next = after_a;
        if (match_b) begin
            pin_next = apply_sel(sel_b, after_a);
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
        end
    end
endmodule

// ---- hw/tmso_top.v ----
// timer match status and output control block with register port and interrupt
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "tmso_defs.vh"
module tmso_top (
    input wire clk,                          // timer clock, 200 MHz
    input wire reset_n,                      // async reset, active low
    input wire match_a,                      // up_counter equals compare_value_a, pulse
    input wire match_b,                      // up_counter equals compare_value_b, pulse
    input wire overflow,                     // up_counter wrapped to zero, pulse
    input wire [`TMSO_ADDR_W-1:0] addr,      // register address
    input wire [7:0] wdata,                  // write data
    input wire wr_stb,                       // write strobe, one cycle
    input wire rd_stb,                       // read strobe, one cycle
    output reg [7:0] rdata,                  // read data, cycle after rd_stb
    output reg irq,                          // level interrupt request
    output wire waveform_output_pin          // waveform output, from flop
);
    wire sel_status;
    wire sel_irq_en;
    wire wr_status;
    wire rd_status;
    wire [2:0] set_vec;
    wire [2:0] wbit_vec;
    wire [2:0] flag_vec;
    wire [7:0] status_view;
    wire irq_next;
    reg [1:0] os_b_reg;
    reg [1:0] os_a_reg;
    reg [2:0] irq_en_reg;
    reg [7:0] rdata_next;

    assign sel_status = (addr == `TMSO_OFS_STATUS);
    assign sel_irq_en = (addr == `TMSO_OFS_IRQ_EN);
    assign wr_status = wr_stb & sel_status;
    assign rd_status = rd_stb & sel_status;

    // index 2 is match B, 1 match A, 0 overflow, as in the register
    assign set_vec = {match_b, match_a, overflow};
    assign wbit_vec = {wdata[`TMSO_BIT_MATCH_B], wdata[`TMSO_BIT_MATCH_A],
                       wdata[`TMSO_BIT_OVERFLOW]};

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_flag
            tmso_flag_cell u_cell (
                .clk(clk),
                .reset_n(reset_n),
                .set_pulse(set_vec[i]),
                .rd_reg(rd_status),
                .wr_reg(wr_status),
                .wr_bit(wbit_vec[i]),
                .flag_reg(flag_vec[i])
            );
        end
    endgenerate

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            os_b_reg <= `TMSO_OS_RESET;
            os_a_reg <= `TMSO_OS_RESET;
        end else if (wr_status) begin
            os_b_reg <= wdata[`TMSO_BIT_OS_B_HI:`TMSO_BIT_OS_B_LO];
            os_a_reg <= wdata[`TMSO_BIT_OS_A_HI:`TMSO_BIT_OS_A_LO];
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_en_reg <= `TMSO_IRQ_EN_RESET;
        end else if (wr_stb && sel_irq_en) begin
            irq_en_reg <= wdata[`TMSO_BIT_MATCH_B:`TMSO_BIT_OVERFLOW];
        end
    end

    assign status_view = {flag_vec, `TMSO_RESERVED_VAL, os_b_reg, os_a_reg};

    always @* begin
        rdata_next = 8'h00;
        if (rd_stb) begin
            case (addr)
                `TMSO_OFS_STATUS: rdata_next = status_view;
                `TMSO_OFS_IRQ_EN: rdata_next = {irq_en_reg, 5'h00};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // read data valid only in the cycle after the strobe
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rdata_next;
        end
    end

    assign irq_next = |(flag_vec & irq_en_reg);

    // registered, so irq lags the flag by one cycle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end

    tmso_wave_out u_wave (
        .clk(clk),
        .reset_n(reset_n),
        .match_a(match_a),
        .match_b(match_b),
        .sel_a(os_a_reg),
        .sel_b(os_b_reg),
        .pin_reg(waveform_output_pin)
    );
endmodule

// ---- verification/tmso_assertions.sv ----
// assertion checker of tmso_top
`timescale 1ns/10ps
module tmso_checker (
    input wire clk, // clock
    input wire reset_n, // reset
    input wire match_a, // event a
    input wire match_b, // event b
    input wire overflow, // wrap
    input wire [1:0] addr, // address
    input wire [7:0] wdata, // data in
    input wire wr_stb, // write
    input wire rd_stb, // read
    input wire [7:0] rdata, // data out
    input wire irq, // interrupt
    input wire waveform_output_pin // pin
);
reg [7:0] en_reg;
reg [3:0] sel_reg;
// mirrors only, so the irq and pin checks know the enable and select fields
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        en_reg <= 8'h00;
        sel_reg <= 4'h0;
    end else if (wr_stb) begin
        if (addr == 2'h1) en_reg <= wdata;
        if (addr == 2'h0) sel_reg <= wdata[3:0];
    end
end
default clocking cb @(posedge clk); endclocking
default disable iff (!reset_n);
sequence s_rd; rd_stb && addr == 2'h0; endsequence
property p_rsv; s_rd |=> rdata[4]; endproperty
a_rsv: assert property (p_rsv) else $error("bit 4 low");
property p_fb; match_b ##1 !wr_stb ##1 s_rd |=> rdata[7]; endproperty
a_fb: assert property (p_fb) else $error("b flag");
property p_fa; match_a ##1 !wr_stb ##1 s_rd |=> rdata[6]; endproperty
a_fa: assert property (p_fa) else $error("a flag");
property p_fo; overflow ##1 !wr_stb ##1 s_rd |=> rdata[5]; endproperty
a_fo: assert property (p_fo) else $error("wrap flag");
property p_ib; match_b ##1 en_reg[7] |=> irq; endproperty
a_ib: assert property (p_ib) else $error("b irq");
property p_ia; match_a ##1 en_reg[6] |=> irq; endproperty
a_ia: assert property (p_ia) else $error("a irq");
property p_io; overflow ##1 en_reg[5] |=> irq; endproperty
a_io: assert property (p_io) else $error("wrap irq");
property p_pb; match_b && sel_reg[3:2] == 2'h2 |=> waveform_output_pin; endproperty
a_pb: assert property (p_pb) else $error("b pin");
property p_pa; match_a && !match_b && sel_reg[1:0] == 2'h3 |=>
    waveform_output_pin != $past(waveform_output_pin); endproperty
a_pa: assert property (p_pa) else $error("a pin");
endmodule
bind tmso_top tmso_checker chk_u (.clk(clk), .reset_n(reset_n), .match_a(match_a),
    .match_b(match_b), .overflow(overflow), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .waveform_output_pin(waveform_output_pin));

// ---- verification/tmso_test.sv ----
// self-checking bench of tmso_top
`timescale 1ns/10ps
module timer_match_status_output_test;
reg clk = 1'b0;
reg reset_n = 1'b0;
reg match_a = 1'b0, match_b = 1'b0, overflow = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
reg [1:0] addr = 2'h0;
reg [7:0] wdata = 8'h00;
wire [7:0] rdata;
wire irq, pin;
integer failures = 0, compares = 0, cycles = 0, i;
reg p;
reg [1:0] c;
always #2.5 clk = ~clk;
tmso_top dut_u (.clk(clk), .reset_n(reset_n), .match_a(match_a), .match_b(match_b),
    .overflow(overflow), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .irq(irq), .waveform_output_pin(pin));
task print_verdict;
    begin
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end
endtask
always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
        failures = failures + 1;
        print_verdict;
    end
end
task chk(input [7:0] got, input [7:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    end
endtask
task wr(input [1:0] a, input [7:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    end
endtask
task rd(input [1:0] a, input [7:0] e);
    begin
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 chk(rdata, e);
    end
endtask
task ev(input [2:0] v);
    begin
        @(posedge clk);
        {match_b, match_a, overflow} <= v;
        @(posedge clk);
        {match_b, match_a, overflow} <= 3'b000;
    end
endtask
task t_reset;
    begin
        #1 chk({6'h00, irq, pin}, 8'h00);
        rd(2'h0, 8'h10);
        wr(2'h0, 8'h00);
        rd(2'h0, 8'h10);
        rd(2'h3, 8'h00);
        wr(2'h2, 8'hff);
        rd(2'h1, 8'h00);
        rd(2'h0, 8'h10);
        $display("test reset done");
    end
endtask
task t_flags;
    begin
        for (i = 0; i < 3; i = i + 1) begin
            ev(3'b001 << i);
            rd(2'h0, (8'h20 << i) | 8'h10);
            wr(2'h0, 8'h20 << i);
            wr(2'h0, 8'h00);
            rd(2'h0, (8'h20 << i) | 8'h10);
            wr(2'h0, 8'h00);
            rd(2'h0, 8'h10);
        end
        ev(3'b010);
        rd(2'h0, 8'h50);
        // armed clear and a new match in one cycle
        @(posedge clk);
        addr <= 2'h0;
        wdata <= 8'h00;
        wr_stb <= 1'b1;
        match_a <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        match_a <= 1'b0;
        rd(2'h0, 8'h50);
        wr(2'h0, 8'h00);
        rd(2'h0, 8'h10);
        $display("test flags done");
    end
endtask
task t_irq;
    begin
        for (i = 0; i < 3; i = i + 1) begin
            wr(2'h1, 8'h20 << i);
            rd(2'h1, 8'h20 << i);
            ev(3'b001 << i);
            @(posedge clk);
            #1 chk({7'h00, irq}, 8'h01);
            wr(2'h1, 8'h00);
            @(posedge clk);
            #1 chk({7'h00, irq}, 8'h00);
            rd(2'h0, (8'h20 << i) | 8'h10);
            wr(2'h0, 8'h00);
        end
        $display("test irq done");
    end
endtask
task t_pin;
    begin
        p = 1'b0;
        // code order chosen so every step moves or holds the pin visibly
        for (i = 0; i < 8; i = i + 1) begin
            c = 16'he1d2 >> (2 * i);
            wr(2'h0, i < 4 ? {6'h00, c} : {4'h0, c, 2'h0});
            ev(i < 4 ? 3'b010 : 3'b100);
            p = c == 2'h1 ? 1'b0 : c == 2'h2 ? 1'b1 : c == 2'h3 ? ~p : p;
            #1 chk({7'h00, pin}, {7'h00, p});
        end
        wr(2'h0, 8'h06);
        ev(3'b110);
        #1 chk({7'h00, pin}, 8'h00);
        $display("test pin done");
    end
endtask
task t_rst2;
    begin
        wr(2'h0, 8'h08);
        ev(3'b100);
        wr(2'h1, 8'h40);
        @(posedge clk);
        #1 chk({6'h00, irq, pin}, 8'h03);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        #1 chk({6'h00, irq, pin}, 8'h00);
        rd(2'h0, 8'h10);
        rd(2'h1, 8'h00);
        $display("test reset again done");
    end
endtask
initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_flags;
    t_irq;
    t_pin;
    t_rst2;
    print_verdict;
end
endmodule
